// [src/aux_io_top.sv]
// Purpose: Camera control, isolated, differential and parallel I/O of a frame grabber
// Assumes: AHB-Lite slave, single 32-bit transfers, one wait state on reads
// Notes: Parallel port pins are two-way as in, out and output enable signals
// How it works
// - Each of the four camera control bits is forced to 0 or 1 or follows one exposure pulse.
// - The four single-ended copies always mirror the camera control bits.
// - The isolated group has two inputs and two outputs.
// - The first bit of each isolated pair is an input and the second an output.
// - Each isolated output is forced by software, follows a timer pulse, or follows the trigger.
// - Two 2-bit differential inputs are readable as status and usable as trigger inputs.
// - Each 8-bit parallel port is wholly input or wholly output by its own direction bit.
// - Pin index zero is the least significant bit of each parallel port value.
// - While latch enable is low a port read returns the live pins.
// - A rising latch enable captures the pins and reads return that capture while it stays high.
// - Two monostables share one start event and each has its own period in microseconds.
// - The trigger input is detected by level or by edge as software selects.
`timescale 1ns/1ps
`default_nettype none
module aux_io_top
	import aux_io_pkg::*;
#(
	parameter int unsigned PORT_W = 8
) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	output logic [3:0] CAMERA_CTRL_OUT,
	output logic [3:0] CTRL_COPY_OUT,
	input wire logic ISO_IN_A_IN,
	input wire logic ISO_IN_B_IN,
	output logic ISO_OUT_A_OUT,
	output logic ISO_OUT_B_OUT,
	input wire logic [1:0] DIFF_IN_A_IN,
	input wire logic [1:0] DIFF_IN_B_IN,
	input wire logic [PORT_W-1:0] PAR_PORT_A_IN,
	output logic [PORT_W-1:0] PAR_PORT_A_OUT,
	output logic PAR_PORT_A_OE_OUT,
	input wire logic [PORT_W-1:0] PAR_PORT_B_IN,
	output logic [PORT_W-1:0] PAR_PORT_B_OUT,
	output logic PAR_PORT_B_OE_OUT,
	input wire logic LATCH_EN_A_IN,
	input wire logic LATCH_EN_B_IN
);
	import aux_io_pkg::*;

	pin_in_t pins_raw;
	pin_in_t pins;
	logic [2*PORT_W-1:0] par_raw;
	logic [2*PORT_W-1:0] par_sync;
	logic [1:0] len_prev;
	logic [PORT_W-1:0] cap_a;
	logic [PORT_W-1:0] cap_b;
	logic [PORT_W-1:0] read_a;
	logic [PORT_W-1:0] read_b;
	logic [7:0] cam_ctrl;
	logic [5:0] iso_ctrl;
	logic [31:0] trig_cfg;
	logic [31:0] period_a;
	logic [31:0] period_b;
	logic [1:0] par_dir;
	logic [2*PORT_W-1:0] par_out;
	logic sw_event;
	logic trig_sel;
	logic trig_prev;
	logic trig_hit;
	logic hit_prev;
	logic mono_start;
	logic pulse_pri;
	logic pulse_sec;
	logic dphase_valid;
	logic dphase_write;
	logic [7:0] dphase_addr;
	logic [31:0] next_rdata;
	logic [3:0] next_cam;
	logic [1:0] next_iso;

	// Picks the requested camera control bit level
	function automatic logic cc_level(input logic [1:0] sel, input logic pri, input logic sec);
		case (cc_src_t'(sel))
			CC_FORCE1: cc_level = 1'b1;
			CC_PULSE_PRI: cc_level = pri;
			CC_PULSE_SEC: cc_level = sec;
			default: cc_level = 1'b0;
		endcase
	endfunction

	// Picks the requested isolated output level
	function automatic logic iso_level(input logic [2:0] sel, input logic pri, input logic sec,
			input logic trg);
		case (iso_src_t'(sel))
			ISO_FORCE1: iso_level = 1'b1;
			ISO_PULSE_PRI: iso_level = pri;
			ISO_PULSE_SEC: iso_level = sec;
			ISO_TRIGGER: iso_level = trg;
			default: iso_level = 1'b0;
		endcase
	endfunction

	// Only the first bit of each isolated pair is sampled as input
	assign pins_raw = '{len: {LATCH_EN_B_IN, LATCH_EN_A_IN}, diff_b: DIFF_IN_B_IN,
		diff_a: DIFF_IN_A_IN, iso_b: ISO_IN_B_IN, iso_a: ISO_IN_A_IN};
	assign par_raw = {PAR_PORT_B_IN, PAR_PORT_A_IN};

	// All external levels pass two flops first
	aux_io_sync #(.WIDTH($bits(pin_in_t))) u_pin_sync (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.async_in(pins_raw),
		.sync_out(pins)
	);

	aux_io_sync #(.WIDTH(2*PORT_W)) u_par_sync (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.async_in(par_raw),
		.sync_out(par_sync)
	);

	// Capture on the rising latch enable; the edge uses synchronised levels only
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			len_prev <= 2'b00;
			cap_a <= '0;
			cap_b <= '0;
		end else begin
			len_prev <= pins.len;
			if (pins.len[0] && !len_prev[0]) begin
				cap_a <= par_sync[PORT_W-1:0];
			end
			if (pins.len[1] && !len_prev[1]) begin
				cap_b <= par_sync[2*PORT_W-1:PORT_W];
			end
		end
	end

	// Live pins while latch is low, capture while high; the capture is valid
	// one cycle after the rising edge, so the edge cycle still shows live pins
	always_comb begin
		read_a = (pins.len[0] && len_prev[0]) ? cap_a : par_sync[PORT_W-1:0];
		read_b = (pins.len[1] && len_prev[1]) ? cap_b : par_sync[2*PORT_W-1:PORT_W];
	end

	// Trigger source selection among isolated and differential inputs
	always_comb begin
		case (trig_src_t'(trig_cfg[TRIG_SRC_LSB +: 3]))
			TRG_ISO_A: trig_sel = pins.iso_a;
			TRG_ISO_B: trig_sel = pins.iso_b;
			TRG_DIFF_A1: trig_sel = pins.diff_a[0];
			TRG_DIFF_A2: trig_sel = pins.diff_a[1];
			TRG_DIFF_B1: trig_sel = pins.diff_b[0];
			TRG_DIFF_B2: trig_sel = pins.diff_b[1];
			TRG_SOFTWARE: trig_sel = 1'b0;
			default: trig_sel = 1'b0;
		endcase
		// Inversion lets an active-low sensor use the same level and edge logic
		if (trig_cfg[TRIG_POL_BIT]) begin
			trig_sel = !trig_sel;
		end
	end

	// Level or edge detection of the selected trigger input
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			trig_prev <= 1'b0;
			trig_hit <= 1'b0;
			hit_prev <= 1'b0;
		end else begin
			trig_prev <= trig_sel;
			hit_prev <= trig_hit;
			if (trig_cfg[TRIG_EDGE_BIT]) begin
				trig_hit <= trig_sel && !trig_prev;
			end else begin
				trig_hit <= trig_sel;
			end
		end
	end

	// One shared start for both monostables: trigger or software event. Without
	// the retrigger bit a held level starts the timers once, on its first hit;
	// edge hits last one cycle, so the same test serves both detection modes
	always_comb begin
		if (trig_src_t'(trig_cfg[TRIG_SRC_LSB +: 3]) == TRG_SOFTWARE) begin
			mono_start = sw_event;
		end else begin
			mono_start = trig_hit && (trig_cfg[MONO_SRC_LSB] || !hit_prev);
		end
	end

	aux_io_mono #(.TICK(TICK_CYCLES)) u_mono_pri (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.start_in(mono_start),
		.period_us_in(period_a),
		.pulse_out(pulse_pri)
	);

	aux_io_mono #(.TICK(TICK_CYCLES)) u_mono_sec (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.start_in(mono_start),
		.period_us_in(period_b),
		.pulse_out(pulse_sec)
	);

	// Output source muxes, repeated per bit
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_cam
			assign next_cam[gi] = cc_level(cam_ctrl[2*gi +: 2], pulse_pri, pulse_sec);
		end
		for (gi = 0; gi < 2; gi++) begin : g_iso
			assign next_iso[gi] = iso_level(iso_ctrl[3*gi +: 3], pulse_pri, pulse_sec,
				trig_hit);
		end
	endgenerate

	// Registered pin drivers; copies share the same next value so never diverge
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			CAMERA_CTRL_OUT <= '0;
			CTRL_COPY_OUT <= '0;
			ISO_OUT_A_OUT <= 1'b0;
			ISO_OUT_B_OUT <= 1'b0;
			PAR_PORT_A_OUT <= '0;
			PAR_PORT_B_OUT <= '0;
			PAR_PORT_A_OE_OUT <= 1'b0;
			PAR_PORT_B_OE_OUT <= 1'b0;
		end else begin
			CAMERA_CTRL_OUT <= next_cam;
			CTRL_COPY_OUT <= next_cam;
			ISO_OUT_A_OUT <= next_iso[0];
			ISO_OUT_B_OUT <= next_iso[1];
			PAR_PORT_A_OUT <= par_out[PORT_W-1:0];
			PAR_PORT_B_OUT <= par_out[2*PORT_W-1:PORT_W];
			PAR_PORT_A_OE_OUT <= par_dir[0];
			PAR_PORT_B_OE_OUT <= par_dir[1];
		end
	end

	// AHB-Lite address phase capture; always OKAY, reads take one wait state
	// The capture waits for HREADY so a stalled data phase keeps its address
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			dphase_valid <= 1'b0;
			dphase_write <= 1'b0;
			dphase_addr <= '0;
		end else if (HREADY_IN) begin
			dphase_valid <= HSEL_IN && HTRANS_IN[1];
			dphase_write <= HWRITE_IN;
			dphase_addr <= HADDR_IN[7:0];
		end
	end

	// Register writes in the data phase; unmapped offsets are ignored
	// The software start is a one-cycle strobe, cleared on the next edge
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			cam_ctrl <= '0;
			iso_ctrl <= '0;
			trig_cfg <= {RESET_ZERO[31:3], TRG_NONE};
			period_a <= RESET_ZERO;
			period_b <= RESET_ZERO;
			par_dir <= 2'b00;
			par_out <= '0;
			sw_event <= 1'b0;
		end else begin
			sw_event <= 1'b0;
			if (dphase_valid && dphase_write) begin
				if (dphase_addr == OFS_CAM_CTRL) begin
					cam_ctrl <= HWDATA_IN[7:0];
				end else if (dphase_addr == OFS_ISO_CTRL) begin
					iso_ctrl <= HWDATA_IN[5:0];
				end else if (dphase_addr == OFS_TRIG_CFG) begin
					trig_cfg <= HWDATA_IN;
				end else if (dphase_addr == OFS_MONO_A) begin
					period_a <= HWDATA_IN;
				end else if (dphase_addr == OFS_MONO_B) begin
					period_b <= HWDATA_IN;
				end else if (dphase_addr == OFS_PAR_DIR) begin
					par_dir <= HWDATA_IN[1:0];
				end else if (dphase_addr == OFS_PAR_OUT) begin
					par_out <= HWDATA_IN[2*PORT_W-1:0];
				end else if (dphase_addr == OFS_SW_EVENT) begin
					sw_event <= HWDATA_IN[0];
				end
			end
		end
	end

	// Read mux, address decided from the registered address phase
	always_comb begin
		next_rdata = RESET_ZERO;
		if (dphase_addr == OFS_CAM_CTRL) begin
			next_rdata[7:0] = cam_ctrl;
		end else if (dphase_addr == OFS_ISO_CTRL) begin
			next_rdata[5:0] = iso_ctrl;
		end else if (dphase_addr == OFS_TRIG_CFG) begin
			next_rdata = trig_cfg;
		end else if (dphase_addr == OFS_MONO_A) begin
			next_rdata = period_a;
		end else if (dphase_addr == OFS_MONO_B) begin
			next_rdata = period_b;
		end else if (dphase_addr == OFS_PAR_DIR) begin
			next_rdata[1:0] = par_dir;
		end else if (dphase_addr == OFS_PAR_OUT) begin
			next_rdata[2*PORT_W-1:0] = par_out;
		end else if (dphase_addr == OFS_PAR_IN) begin
			next_rdata[2*PORT_W-1:0] = {read_b, read_a};
		end else if (dphase_addr == OFS_STATUS) begin
			next_rdata[STAT_DIFF_LSB +: 4] = {pins.diff_b, pins.diff_a};
			next_rdata[STAT_ISO_LSB +: 2] = {pins.iso_b, pins.iso_a};
			next_rdata[STAT_PULSE_LSB +: 2] = {pulse_sec, pulse_pri};
			next_rdata[STAT_TRIG_BIT] = trig_hit;
			next_rdata[STAT_LEN_LSB +: 2] = pins.len;
		end
	end

	// Read data is loaded only in the wait cycle of a read and then held, so the
	// master finds a stable word at the edge that ends the data phase
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			HRDATA_OUT <= RESET_ZERO;
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT <= 1'b0;
		end else begin
			if (dphase_valid && !dphase_write && !HREADYOUT_OUT) begin
				HRDATA_OUT <= next_rdata;
			end
			// One wait state per read gives the read mux a full registered cycle
			HREADYOUT_OUT <= !(HREADY_IN && HSEL_IN && HTRANS_IN[1] && !HWRITE_IN);
			HRESP_OUT <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [inc/aux_io_pkg.sv]
// Purpose: Shared constants and types for the camera auxiliary I/O block
// Assumes: 200 MHz system clock, AHB-Lite register access with 32-bit data
// Notes: Register offsets are byte addresses of aligned words
package aux_io_pkg;
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned TICK_US = 1;
	localparam int unsigned TICK_CYCLES = CLK_MHZ * TICK_US;
	localparam int unsigned SYNC_STAGES = 2;

	// Register byte offsets
	localparam logic [7:0] OFS_CAM_CTRL = 8'h00;
	localparam logic [7:0] OFS_ISO_CTRL = 8'h04;
	localparam logic [7:0] OFS_TRIG_CFG = 8'h08;
	localparam logic [7:0] OFS_MONO_A = 8'h0c;
	localparam logic [7:0] OFS_MONO_B = 8'h10;
	localparam logic [7:0] OFS_PAR_DIR = 8'h14;
	localparam logic [7:0] OFS_PAR_OUT = 8'h18;
	localparam logic [7:0] OFS_PAR_IN = 8'h1c;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_SW_EVENT = 8'h24;

	// Camera control bit source, two bits per output
	typedef enum logic [1:0] {
		CC_FORCE0,
		CC_FORCE1,
		CC_PULSE_PRI,
		CC_PULSE_SEC
	} cc_src_t;

	// Isolated output source, three bits per output
	typedef enum logic [2:0] {
		ISO_FORCE0,
		ISO_FORCE1,
		ISO_PULSE_PRI,
		ISO_PULSE_SEC,
		ISO_TRIGGER
	} iso_src_t;

	// Trigger input selection
	typedef enum logic [2:0] {
		TRG_ISO_A,
		TRG_ISO_B,
		TRG_DIFF_A1,
		TRG_DIFF_A2,
		TRG_DIFF_B1,
		TRG_DIFF_B2,
		TRG_SOFTWARE,
		TRG_NONE
	} trig_src_t;

	// Field positions
	localparam int unsigned TRIG_SRC_LSB = 0;
	localparam int unsigned TRIG_EDGE_BIT = 3;
	localparam int unsigned TRIG_POL_BIT = 4;
	localparam int unsigned MONO_SRC_LSB = 8;
	localparam int unsigned STAT_DIFF_LSB = 0;
	localparam int unsigned STAT_ISO_LSB = 4;
	localparam int unsigned STAT_PULSE_LSB = 6;
	localparam int unsigned STAT_TRIG_BIT = 8;
	localparam int unsigned STAT_LEN_LSB = 9;
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

	// Raw pin group sampled together
	typedef struct packed {
		logic [1:0] len;
		logic [1:0] diff_b;
		logic [1:0] diff_a;
		logic iso_b;
		logic iso_a;
	} pin_in_t;
endpackage

// [src/aux_io_sync.sv]
// Purpose: Two-flop synchroniser for a group of asynchronous pins
// Assumes: One destination clock
// Notes: The first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module aux_io_sync #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	// Double register against metastability
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule
`default_nettype wire

// [src/aux_io_mono.sv]
// Purpose: Monostable exposure pulse timer with 1 us resolution
// Assumes: Start is a one-cycle pulse
// Notes: A start during a running pulse restarts it
`timescale 1ns/1ps
`default_nettype none
module aux_io_mono #(
	parameter int unsigned TICK = 200
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic [31:0] period_us_in,
	output logic pulse_out
);
	logic [31:0] remain;
	logic [15:0] tick_cnt;

	// Microsecond prescaler and remaining-time count
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			remain <= '0;
			tick_cnt <= '0;
			pulse_out <= 1'b0;
		end else if (start_in) begin
			remain <= period_us_in;
			tick_cnt <= '0;
			pulse_out <= (period_us_in != '0);
		end else if (remain != '0) begin
			if (tick_cnt == 16'(TICK - 1)) begin
				tick_cnt <= '0;
				remain <= remain - 32'h0000_0001;
				pulse_out <= (remain != 32'h0000_0001);
			end else begin
				tick_cnt <= tick_cnt + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// [dv/aux_io_top_asserts.sv]
// Purpose: Port checks for the camera auxiliary I/O block
// Assumes: One clock; writes finish with no wait state
// Notes: Camera bit timing allows one extra register stage
`timescale 1ns/1ps
`default_nettype none
module aux_io_top_chk
	import aux_io_pkg::*;
#(
	parameter int unsigned PORT_W = 8
) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	input wire logic [31:0] HRDATA_OUT,
	input wire logic HREADYOUT_OUT,
	input wire logic HRESP_OUT,
	input wire logic [3:0] CAMERA_CTRL_OUT,
	input wire logic [3:0] CTRL_COPY_OUT,
	input wire logic ISO_OUT_A_OUT,
	input wire logic [PORT_W-1:0] PAR_PORT_A_OUT,
	input wire logic PAR_PORT_A_OE_OUT,
	input wire logic PAR_PORT_B_OE_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	logic taken;
	logic rd_t;
	// Transfer accepted at this edge
	assign taken = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
	assign rd_t = taken && !HWRITE_IN;
	// Steps of a register access
	sequence wr_req(logic [7:0] ofs);
		taken && HWRITE_IN && HADDR_IN[7:0] == ofs;
	endsequence
	sequence one_wait;
		!HREADYOUT_OUT ##1 HREADYOUT_OUT;
	endsequence
	chk_read_wait: assert property (rd_t |=> one_wait)
		else $error("read answer not after one wait state");
	chk_write_nowait: assert property (taken && HWRITE_IN |=> HREADYOUT_OUT)
		else $error("write stalled");
	chk_resp_okay: assert property (HRESP_OUT == 1'b0)
		else $error("error response seen");
	chk_rdata_hold: assert property (!rd_t ##1 !rd_t |=> $stable(HRDATA_OUT))
		else $error("read data changed without a read");
	// Reset itself is the cause here, so it must not disable the check
	chk_reset_quiet: assert property (@(posedge CLK_IN) disable iff (1'b0)
		!RST_N_IN |=> CAMERA_CTRL_OUT == 4'h0 && !ISO_OUT_A_OUT
		&& !PAR_PORT_A_OE_OUT && !PAR_PORT_B_OE_OUT)
		else $error("outputs driven during reset");
	chk_dir_write: assert property (wr_req(OFS_PAR_DIR) ##2 1'b1 |=>
		PAR_PORT_A_OE_OUT == $past(HWDATA_IN[0], 2)
		&& PAR_PORT_B_OE_OUT == $past(HWDATA_IN[1], 2))
		else $error("port direction does not follow write");
	chk_out_data: assert property (wr_req(OFS_PAR_OUT) ##2 1'b1 |=>
		PAR_PORT_A_OUT == $past(HWDATA_IN[PORT_W-1:0], 2))
		else $error("port drive data does not follow write");
	chk_cam_force: assert property (wr_req(OFS_CAM_CTRL) ##1
		HWDATA_IN[1:0] == CC_FORCE1 |-> ##[1:2] CAMERA_CTRL_OUT[0])
		else $error("forced camera bit not high");
	chk_copy_mirror: assert property (CTRL_COPY_OUT == CAMERA_CTRL_OUT)
		else $error("copy differs from camera bits");
endmodule
bind aux_io_top aux_io_top_chk #(.PORT_W(PORT_W)) i_chk (.CLK_IN(CLK_IN),
	.RST_N_IN(RST_N_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN),
	.HWRITE_IN(HWRITE_IN), .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN),
	.HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
	.CAMERA_CTRL_OUT(CAMERA_CTRL_OUT), .CTRL_COPY_OUT(CTRL_COPY_OUT),
	.ISO_OUT_A_OUT(ISO_OUT_A_OUT), .PAR_PORT_A_OUT(PAR_PORT_A_OUT),
	.PAR_PORT_A_OE_OUT(PAR_PORT_A_OE_OUT), .PAR_PORT_B_OE_OUT(PAR_PORT_B_OE_OUT));
`default_nettype wire

// [dv/aux_io_far_port.sv]
// Purpose: Far side of one parallel port with its latch enable
// Assumes: Released port lines have no pull resistor
// Notes: A floating line toggles each cycle so stale data never matches
`timescale 1ns/1ps
`default_nettype none
module aux_io_far_port (
	input wire logic clk_in,
	input wire logic [7:0] ext_val_in,
	input wire logic ext_en_in,
	input wire logic freeze_in,
	input wire logic [7:0] dut_val_in,
	input wire logic dut_oe_in,
	output logic [7:0] pin_out,
	output logic len_out
);
	logic [7:0] float_val = 8'h00;
	// Undriven lines change every cycle
	always_ff @(posedge clk_in) begin
		float_val <= ~float_val;
	end
	// Wire level from both drivers' enables
	assign pin_out = dut_oe_in ? dut_val_in : (ext_en_in ? ext_val_in : float_val);
	// Raised to freeze the port, pulled down otherwise
	assign len_out = freeze_in;
endmodule
`default_nettype wire

// [dv/tb_camera_aux_io_ports.sv]
// Purpose: Self-checking bench for the camera auxiliary I/O block
// Assumes: One AHB-Lite master; far side modelled per parallel port
// Notes: Pulse widths use the full 200-cycle microsecond tick
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_camera_aux_io_ports;
	import aux_io_pkg::*;
	typedef struct packed {
		logic [31:0] cam_w;
		logic [3:0] cam_e;
		logic [31:0] iso_w;
		logic [1:0] iso_e;
	} row_t;
	row_t rows [4] = '{'{32'h55, 4'hf, 32'h9, 2'h3}, '{32'h11, 4'h5, 32'h1, 2'h1},
		'{32'h44, 4'ha, 32'h8, 2'h2}, '{32'h0, 4'h0, 32'h0, 2'h0}};
	int errors = 0;
	int n_checks = 0;
	int w0;
	int w1;
	logic clk, rst_n, hsel, hwrite, hready, hresp, iso_a_in, iso_b_in, iso_a, iso_b;
	logic len_a, len_b, pa_oe, pb_oe, ea_en, eb_en, frz_a, frz_b;
	logic [1:0] htrans, dif_a, dif_b;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [3:0] cam, copy;
	logic [7:0] pa_in, pa_out, pb_in, pb_out, ea_val, eb_val;
	aux_io_top i_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
		.HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'b010), .HWDATA_IN(hwdata),
		.HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
		.CAMERA_CTRL_OUT(cam), .CTRL_COPY_OUT(copy), .ISO_IN_A_IN(iso_a_in),
		.ISO_IN_B_IN(iso_b_in), .ISO_OUT_A_OUT(iso_a), .ISO_OUT_B_OUT(iso_b),
		.DIFF_IN_A_IN(dif_a), .DIFF_IN_B_IN(dif_b), .PAR_PORT_A_IN(pa_in),
		.PAR_PORT_A_OUT(pa_out), .PAR_PORT_A_OE_OUT(pa_oe), .PAR_PORT_B_IN(pb_in),
		.PAR_PORT_B_OUT(pb_out), .PAR_PORT_B_OE_OUT(pb_oe), .LATCH_EN_A_IN(len_a),
		.LATCH_EN_B_IN(len_b));
	aux_io_far_port i_far_a (.clk_in(clk), .ext_val_in(ea_val), .ext_en_in(ea_en),
		.freeze_in(frz_a), .dut_val_in(pa_out), .dut_oe_in(pa_oe), .pin_out(pa_in),
		.len_out(len_a));
	aux_io_far_port i_far_b (.clk_in(clk), .ext_val_in(eb_val), .ext_en_in(eb_en),
		.freeze_in(frz_b), .dut_val_in(pb_out), .dut_oe_in(pb_oe), .pin_out(pb_in),
		.len_out(len_b));
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// One single transfer; waits on the slave's ready, never a fixed count
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 40);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 40);
		q = hrdata;
		if (n >= 40) begin
			errors++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		ahb(1'b0, a, 32'h0);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	// High time of the two exposure bits over a fixed span
	task automatic widths(output int a, output int b);
		a = 0;
		b = 0;
		repeat (1000) begin
			@(posedge clk);
			if (cam[0] === 1'b1) a++;
			if (cam[1] === 1'b1) b++;
		end
	endtask
	// Hang guard
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		{hsel, hwrite, iso_a_in, iso_b_in, ea_en, eb_en, frz_a, frz_b} = 8'h0;
		{htrans, dif_a, dif_b, haddr, hwdata, ea_val, eb_val} = '0;
		rst_n = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		`CHK("cam reset", 4'h0, cam)
		`CHK("oe reset", 2'b00, {pb_oe, pa_oe})
		rd(OFS_TRIG_CFG);
		`CHK("trig reset", 32'h7, q)
		rd(8'h40);
		`CHK("unmapped", RESET_ZERO, q)
		done("reset");
		foreach (rows[i]) begin
			wr(OFS_CAM_CTRL, rows[i].cam_w);
			wr(OFS_ISO_CTRL, rows[i].iso_w);
			tick(3);
			`CHK("cam", rows[i].cam_e, cam)
			`CHK("copy", rows[i].cam_e, copy)
			`CHK("iso", rows[i].iso_e, {iso_b, iso_a})
		end
		done("rows");
		wr(OFS_PAR_DIR, 32'h1);
		wr(OFS_PAR_OUT, 32'h5aa5);
		eb_val <= 8'h01;
		eb_en <= 1'b1;
		tick(4);
		rd(OFS_PAR_IN);
		`CHK("oe a", 2'b01, {pb_oe, pa_oe})
		`CHK("pins a", 16'h01a5, q[15:0])
		wr(OFS_PAR_DIR, 32'h2);
		ea_val <= 8'h80;
		ea_en <= 1'b1;
		tick(4);
		rd(OFS_PAR_IN);
		`CHK("oe b", 2'b10, {pb_oe, pa_oe})
		`CHK("pins b", 16'h5a80, q[15:0])
		wr(OFS_PAR_DIR, 32'h0);
		eb_val <= 8'h3c;
		tick(4);
		rd(OFS_PAR_IN);
		`CHK("live", 8'h3c, q[15:8])
		frz_b <= 1'b1;
		tick(4);
		eb_val <= 8'hc3;
		tick(4);
		rd(OFS_PAR_IN);
		`CHK("held", 8'h3c, q[15:8])
		frz_b <= 1'b0;
		tick(4);
		rd(OFS_PAR_IN);
		`CHK("released", 8'hc3, q[15:8])
		done("ports");
		{dif_b, dif_a, iso_b_in, iso_a_in} <= 6'b011001;
		tick(4);
		rd(OFS_STATUS);
		`CHK("status", 6'h16, q[5:0])
		iso_a_in <= 1'b0;
		wr(OFS_MONO_A, 32'h1);
		wr(OFS_MONO_B, 32'h2);
		wr(OFS_TRIG_CFG, 32'h6);
		wr(OFS_CAM_CTRL, 32'he);
		wr(OFS_SW_EVENT, 32'h1);
		widths(w0, w1);
		`CHK("pri width", TICK_CYCLES, w0)
		`CHK("sec width", 2 * TICK_CYCLES, w1)
		wr(OFS_TRIG_CFG, 32'h8);
		wr(OFS_ISO_CTRL, 32'h4);
		iso_a_in <= 1'b1;
		widths(w0, w1);
		`CHK("edge once", TICK_CYCLES, w0)
		wr(OFS_TRIG_CFG, 32'h100);
		tick(600);
		`CHK("level hold", 1'b1, cam[0])
		`CHK("iso trig", 1'b1, iso_a)
		iso_a_in <= 1'b0;
		tick(300);
		`CHK("level end", 1'b0, cam[0])
		// Level mode without retrigger: a held input starts one pulse only
		wr(OFS_TRIG_CFG, 32'h0);
		iso_a_in <= 1'b1;
		widths(w0, w1);
		`CHK("level once", TICK_CYCLES, w0)
		done("triggers");
		report_and_stop();
	end
endmodule
`default_nettype wire
